/* File: rtl/servo_filter_pkg.sv */
package servo_filter_pkg;
	// register word indices on the avalon word address
	localparam logic [4:0] OFS_COND_SEL = 5'h00;
	localparam logic [4:0] OFS_FORCE_THR = 5'h01;
	localparam logic [4:0] OFS_SPEED_THR = 5'h02;
	localparam logic [4:0] OFS_ACCEL_THR = 5'h03;
	localparam logic [4:0] OFS_POSERR_THR = 5'h04;
	localparam logic [4:0] OFS_LAG_TC = 5'h05;
	localparam logic [4:0] OFS_S2_FREQ = 5'h06;
	localparam logic [4:0] OFS_S2_Q = 5'h07;
	localparam logic [4:0] OFS_NOTCH_EN = 5'h08;
	localparam logic [4:0] OFS_N1_FREQ = 5'h09;
	localparam logic [4:0] OFS_N1_Q = 5'h0A;
	localparam logic [4:0] OFS_N1_DEPTH = 5'h0B;
	localparam logic [4:0] OFS_N2_FREQ = 5'h0C;
	localparam logic [4:0] OFS_N2_Q = 5'h0D;
	localparam logic [4:0] OFS_N2_DEPTH = 5'h0E;
	localparam logic [4:0] OFS_POS_INT_TIME = 5'h0F;
	localparam logic [4:0] OFS_SPEED_GAIN = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h11;
	localparam int NREG = 17;

	// reset values, listed from index 16 down to index 0
	localparam logic [NREG-1:0][15:0] CFG_RESET = {
		16'h0028, 16'h0000, 16'h0000, 16'h0046, 16'h1388, 16'h0000,
		16'h0046, 16'h1388, 16'h0000, 16'h0032, 16'h1388, 16'h0064,
		16'h0000, 16'h0000, 16'h0000, 16'h00C8, 16'h0000};

	// switching condition codes in the lowest digit
	localparam logic [3:0] COND_FORCE = 4'h0;
	localparam logic [3:0] COND_SPEED = 4'h1;
	localparam logic [3:0] COND_ACCEL = 4'h2;
	localparam logic [3:0] COND_POSERR = 4'h3;
	localparam logic [3:0] COND_NONE = 4'h4;
	localparam logic [3:0] DIGIT_ON = 4'h1;

	// status bit positions
	localparam int ST_P_MODE = 0;
	localparam int ST_POS_INT_ON = 1;
	localparam int ST_S2_ON = 2;
	localparam int ST_N1_ON = 3;
	localparam int ST_N2_ON = 4;

	localparam logic [15:0] S2_OFF_FREQ = 16'h1388;
	localparam logic [15:0] Q_MIN = 16'h0032;
	localparam int Q_SCALE = 6553600;
	localparam int DEPTH_FULL = 1000;
	localparam int FRAC = 12;
	localparam longint TWO_PI_Q16 = 411775;
	// setting units in microseconds
	localparam int LAG_UNIT_US = 10;
	localparam int POSINT_UNIT_US = 100;

	typedef struct packed {
		logic signed [31:0] low;
		logic signed [31:0] band;
		logic signed [31:0] y;
	} svf_t;

	typedef struct packed {
		logic [NREG-1:0][15:0] cfg;
		logic waitreq;
		logic [31:0] rdata;
		logic p_mode;
		logic signed [31:0] lag_y;
		svf_t s2;
		svf_t n1;
		svf_t n2;
		logic signed [47:0] pos_acc;
		logic [15:0] force_out;
		logic [15:0] pos_int_out;
		logic out_valid;
	} state_t;
endpackage

/* File: rtl/pi_mode_switch_force_filter.sv */
// How it works
// - lowest select digit picks force, speed, accel, position error or none.
// - speed loop runs PI, drops to P while selected condition holds.
// - force mode: P while force reference magnitude exceeds threshold, reset 200.
// - speed mode: P while speed reference magnitude exceeds threshold.
// - accel mode: P while acceleration magnitude exceeds threshold.
// - error mode: P while position error exceeds threshold in reference units.
// - position error condition only switches while in position control.
// - force reference runs lag, second stage, notch one, notch two in series.
// - lag time constant in 0.01 ms steps, reset 100.
// - second stage takes frequency and Q; frequency 5000 bypasses it.
// - notch enable digit 0 turns notch one on, digit 2 notch two.
// - notch one takes frequency, Q in 0.01, depth in 0.001.
// - notch two same ranges, resets 5000 Hz, Q 70, depth 0.
// - notch cuts gain near its frequency; bigger Q narrows it.
// - position loop integral time constant in 0.1 ms steps, reset 0.
// - speed loop gain in hertz is held as a setting.
`timescale 1ns/1ps
`default_nettype none
module pi_mode_switch_force_filter #(
	parameter int SAMPLE_RATE_HZ = 32000
) (
	input wire logic clk, // 125 MHz
	input wire logic reset, // sync, active high
	input wire logic [4:0] address, // avalon word address
	input wire logic read, // avalon read
	input wire logic write, // avalon write
	input wire logic [3:0] byteenable, // avalon byte lanes
	input wire logic [31:0] writedata, // avalon write data
	output logic [31:0] readdata, // avalon read data
	output logic waitrequest, // avalon wait
	input wire logic sample_valid, // new sample strobe
	input wire logic signed [15:0] force_ref, // force ref, 1% rated
	input wire logic signed [15:0] speed_ref, // speed ref, mm/s
	input wire logic signed [15:0] accel_ref, // ref accel, mm/s^2
	input wire logic signed [15:0] pos_err, // position error, ref units
	input wire logic position_mode, // position control active
	output logic p_control, // 1: P only, 0: PI
	output logic signed [15:0] force_filt, // filtered force reference
	output logic signed [15:0] pos_integral, // position integral term
	output logic out_valid // filtered outputs updated
);
	localparam int TS_US = 1000000 / SAMPLE_RATE_HZ;

	servo_filter_pkg::state_t s_ff;
	servo_filter_pkg::state_t nxt_s;
	logic req;
	logic [3:0] sel;
	logic cond_force;
	logic cond_speed;
	logic cond_accel;
	logic cond_poserr;
	logic s2_on;
	logic n1_on;
	logic n2_on;
	logic pos_int_on;
	logic signed [31:0] x_in;
	logic signed [31:0] lag_v;
	logic signed [63:0] prod;
	logic [31:0] alpha;
	logic signed [47:0] acc_v;

	function automatic logic [15:0] mag(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
		if (v > 64'sd32767)
			return 16'sh7FFF;
		if (v < -64'sd32768)
			return 16'sh8000;
		return 16'(v);
	endfunction

	// frequency word in Q16 per sample; small angle keeps it linear
	function automatic logic signed [31:0] f_coef(input logic [15:0] f);
		return 32'(64'(f) * servo_filter_pkg::TWO_PI_Q16 / SAMPLE_RATE_HZ);
	endfunction

	// damping 1/Q in Q16; a zero Q is clamped to avoid a divide by zero
	function automatic logic signed [31:0] d_coef(input logic [15:0] q);
		logic [15:0] qq;
		qq = (q < servo_filter_pkg::Q_MIN) ? servo_filter_pkg::Q_MIN : q;
		return 32'(servo_filter_pkg::Q_SCALE / int'(qq));
	endfunction

	// state variable section: low pass for the second stage, notch else
	function automatic servo_filter_pkg::svf_t svf(
		input logic signed [31:0] x,
		input servo_filter_pkg::svf_t st,
		input logic [15:0] freq,
		input logic [15:0] q,
		input logic [15:0] depth,
		input logic notch
	);
		servo_filter_pkg::svf_t r;
		logic signed [31:0] f;
		logic signed [31:0] d;
		logic signed [31:0] hi;
		logic signed [31:0] nt;
		logic signed [63:0] p;
		f = f_coef(freq);
		d = d_coef(q);
		r = st;
		p = 64'(st.band) * 64'(f);
		r.low = st.low + 32'(p >>> 16);
		p = 64'(st.band) * 64'(d);
		hi = x - r.low - 32'(p >>> 16);
		p = 64'(hi) * 64'(f);
		r.band = st.band + 32'(p >>> 16);
		nt = hi + r.low;
		// depth 0 is a full notch, 1000 lets the signal through
		p = 64'(x - nt) * $signed(64'(depth))
			/ 64'(servo_filter_pkg::DEPTH_FULL);
		r.y = notch ? nt + 32'(p) : r.low;
		return r;
	endfunction

	// a bypassed stage tracks its input so enabling it causes no bump
	function automatic servo_filter_pkg::svf_t svf_idle(
		input logic signed [31:0] x
	);
		servo_filter_pkg::svf_t r;
		r.low = x;
		r.band = 32'sh0;
		r.y = x;
		return r;
	endfunction

	function automatic logic [15:0] reg_rd(
		input servo_filter_pkg::state_t st,
		input logic [4:0] a,
		input logic [4:0] stat
	);
		if (a == servo_filter_pkg::OFS_STATUS)
			return {11'h000, stat};
		if (int'(a) < servo_filter_pkg::NREG)
			return st.cfg[a];
		return 16'h0000;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		nxt_s.out_valid = 1'b0;
		req = read | write;
		sel = s_ff.cfg[servo_filter_pkg::OFS_COND_SEL][3:0];
		s2_on = s_ff.cfg[servo_filter_pkg::OFS_S2_FREQ]
			!= servo_filter_pkg::S2_OFF_FREQ;
		n1_on = s_ff.cfg[servo_filter_pkg::OFS_NOTCH_EN][3:0]
			== servo_filter_pkg::DIGIT_ON;
		n2_on = s_ff.cfg[servo_filter_pkg::OFS_NOTCH_EN][11:8]
			== servo_filter_pkg::DIGIT_ON;
		pos_int_on = s_ff.cfg[servo_filter_pkg::OFS_POS_INT_TIME]
			!= 16'h0000;

		// avalon: one wait cycle, then the answer with waitrequest low
		if (req && s_ff.waitreq) begin
			nxt_s.waitreq = 1'b0;
			nxt_s.rdata = 32'h00000000;
			if (read)
				nxt_s.rdata = {16'h0000, reg_rd(s_ff, address,
					{n2_on, n1_on, s2_on, pos_int_on, s_ff.p_mode})};
		end else begin
			nxt_s.waitreq = 1'b1;
			if (write && !s_ff.waitreq
				&& int'(address) < servo_filter_pkg::NREG) begin
				if (byteenable[0])
					nxt_s.cfg[address][7:0] = writedata[7:0];
				if (byteenable[1])
					nxt_s.cfg[address][15:8] = writedata[15:8];
			end
		end

		// mode switch, evaluated every clock on the live references
		cond_force = mag(force_ref)
			> s_ff.cfg[servo_filter_pkg::OFS_FORCE_THR];
		cond_speed = mag(speed_ref)
			> s_ff.cfg[servo_filter_pkg::OFS_SPEED_THR];
		cond_accel = mag(accel_ref)
			> s_ff.cfg[servo_filter_pkg::OFS_ACCEL_THR];
		cond_poserr = position_mode && mag(pos_err)
			> s_ff.cfg[servo_filter_pkg::OFS_POSERR_THR];
		case (sel)
			servo_filter_pkg::COND_FORCE: nxt_s.p_mode = cond_force;
			servo_filter_pkg::COND_SPEED: nxt_s.p_mode = cond_speed;
			servo_filter_pkg::COND_ACCEL: nxt_s.p_mode = cond_accel;
			servo_filter_pkg::COND_POSERR: nxt_s.p_mode = cond_poserr;
			// code 4 and the unused codes keep the loop in PI
			default: nxt_s.p_mode = 1'b0;
		endcase

		// force reference chain: lag, second stage, notch one, notch two
		x_in = 32'(force_ref) <<< servo_filter_pkg::FRAC;
		alpha = 32'((64'(TS_US) << 16) / (64'(s_ff.cfg[
			servo_filter_pkg::OFS_LAG_TC]) * servo_filter_pkg::LAG_UNIT_US
			+ TS_US));
		prod = 64'(x_in - s_ff.lag_y) * $signed({32'h0, alpha});
		lag_v = s_ff.lag_y + 32'(prod >>> 16);
		acc_v = s_ff.pos_acc;
		if (sample_valid) begin
			nxt_s.out_valid = 1'b1;
			nxt_s.lag_y = lag_v;
			nxt_s.s2 = s2_on ? svf(lag_v, s_ff.s2,
				s_ff.cfg[servo_filter_pkg::OFS_S2_FREQ],
				s_ff.cfg[servo_filter_pkg::OFS_S2_Q],
				16'h0000, 1'b0) : svf_idle(lag_v);
			nxt_s.n1 = n1_on ? svf(nxt_s.s2.y, s_ff.n1,
				s_ff.cfg[servo_filter_pkg::OFS_N1_FREQ],
				s_ff.cfg[servo_filter_pkg::OFS_N1_Q],
				s_ff.cfg[servo_filter_pkg::OFS_N1_DEPTH],
				1'b1) : svf_idle(nxt_s.s2.y);
			nxt_s.n2 = n2_on ? svf(nxt_s.n1.y, s_ff.n2,
				s_ff.cfg[servo_filter_pkg::OFS_N2_FREQ],
				s_ff.cfg[servo_filter_pkg::OFS_N2_Q],
				s_ff.cfg[servo_filter_pkg::OFS_N2_DEPTH],
				1'b1) : svf_idle(nxt_s.n1.y);
			nxt_s.force_out = sat16(64'(nxt_s.n2.y)
				>>> servo_filter_pkg::FRAC);
			// integral kept in error-microseconds, scaled on output
			if (pos_int_on) begin
				acc_v = s_ff.pos_acc + 48'(64'(pos_err) * TS_US);
				nxt_s.pos_acc = acc_v;
				nxt_s.pos_int_out = sat16(64'(acc_v) / $signed(64'(
					s_ff.cfg[servo_filter_pkg::OFS_POS_INT_TIME]
					* servo_filter_pkg::POSINT_UNIT_US)));
			end
		end
		// no accumulation can survive a zero time constant
		if (!pos_int_on) begin
			nxt_s.pos_acc = 48'sh0;
			nxt_s.pos_int_out = 16'h0000;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '0;
			s_ff.cfg <= servo_filter_pkg::CFG_RESET;
			s_ff.waitreq <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign readdata = s_ff.rdata;
	assign waitrequest = s_ff.waitreq;
	assign p_control = s_ff.p_mode;
	assign force_filt = s_ff.force_out;
	assign pos_integral = s_ff.pos_int_out;
	assign out_valid = s_ff.out_valid;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_req_wait;
		(read || write) && waitrequest;
	endsequence
	sequence s_req_done;
		(read || write) && !waitrequest;
	endsequence

	chk_bus_one_wait: assert property (
		s_req_wait |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not after exactly one wait cycle");

	chk_gain_readback: assert property (
		s_req_done and (write && address == servo_filter_pkg::OFS_SPEED_GAIN
		&& byteenable[1:0] == 2'b11) |-> ##2 s_ff.cfg[
		servo_filter_pkg::OFS_SPEED_GAIN] == $past(writedata[15:0], 2))
		else $error("speed loop gain write lost");

	chk_none_stays_pi: assert property (
		s_ff.cfg[servo_filter_pkg::OFS_COND_SEL][3:0]
		== servo_filter_pkg::COND_NONE |=> !p_control)
		else $error("P control with switching unused");

	chk_force_switch: assert property (
		sel == servo_filter_pkg::COND_FORCE && $stable(sel)
		|=> p_control == $past(mag(force_ref)
		> s_ff.cfg[servo_filter_pkg::OFS_FORCE_THR]))
		else $error("force switching wrong");

	chk_speed_switch: assert property (
		sel == servo_filter_pkg::COND_SPEED
		&& mag(speed_ref) == s_ff.cfg[servo_filter_pkg::OFS_SPEED_THR]
		|=> !p_control)
		else $error("speed equal to threshold must stay PI");

	chk_accel_switch: assert property (
		sel == servo_filter_pkg::COND_ACCEL
		&& mag(accel_ref) > s_ff.cfg[servo_filter_pkg::OFS_ACCEL_THR]
		|=> p_control)
		else $error("acceleration switching missed");

	chk_poserr_mode: assert property (
		sel == servo_filter_pkg::COND_POSERR && !position_mode
		|=> !p_control)
		else $error("position error switched outside position control");

	chk_pi_return: assert property (
		p_control && sel == servo_filter_pkg::COND_FORCE
		&& !cond_force |=> !p_control)
		else $error("PI not restored");

	chk_valid_follows: assert property (
		sample_valid |=> out_valid ##1 (out_valid == $past(sample_valid)))
		else $error("filtered output strobe misplaced");

	chk_bypass_passes: assert property (
		sample_valid && !s2_on && !n1_on && !n2_on
		|=> force_filt == sat16(64'(s_ff.lag_y) >>> servo_filter_pkg::FRAC))
		else $error("bypassed stages altered the lag output");

	chk_posint_zero: assert property (
		!pos_int_on [*2] |-> pos_integral == 16'h0000)
		else $error("position integral active with zero time");

	// idle bus must show wait, so a late request never sees a stale answer
	chk_idle_wait_high: assert property (
		!(read || write) |=> waitrequest)
		else $error("waitrequest low without a request");

	// full 16-bit writes only; lane masks are left to the bench
	chk_write_lands: assert property (
		s_req_done and (write && int'(address) < servo_filter_pkg::NREG
		&& byteenable[1:0] == 2'b11) |=> s_ff.cfg[$past(address)]
		== $past(writedata[15:0]))
		else $error("register write did not land");

	chk_unused_codes_pi: assert property (
		sel > servo_filter_pkg::COND_NONE |=> !p_control)
		else $error("P control on an unused select code");

	chk_poserr_switch: assert property (
		sel == servo_filter_pkg::COND_POSERR && position_mode
		&& mag(pos_err) > s_ff.cfg[servo_filter_pkg::OFS_POSERR_THR]
		|=> p_control)
		else $error("position error switching missed");

	chk_lag_zero_pass: assert property (
		sample_valid && s_ff.cfg[servo_filter_pkg::OFS_LAG_TC] == 16'h0000
		|=> s_ff.lag_y == $past(32'(force_ref) <<< servo_filter_pkg::FRAC))
		else $error("zero lag time constant did not pass through");

	// stage routing: a disabled stage hands its input straight on
	chk_s2_off_follows: assert property (
		sample_valid && !s2_on |=> s_ff.s2.y == s_ff.lag_y)
		else $error("disabled second stage altered its input");

	chk_n1_off_follows: assert property (
		sample_valid && !n1_on |=> s_ff.n1.y == s_ff.s2.y)
		else $error("disabled first notch altered its input");

	chk_n2_off_follows: assert property (
		sample_valid && !n2_on |=> s_ff.n2.y == s_ff.n1.y)
		else $error("disabled second notch altered its input");

	chk_integral_holds: assert property (
		pos_int_on && !sample_valid |=> $stable(pos_integral))
		else $error("position integral moved without a sample");

	chk_status_p_bit: assert property (
		s_req_wait and (read && address == servo_filter_pkg::OFS_STATUS)
		|=> readdata[0] == $past(p_control))
		else $error("status shows the wrong control mode");
endmodule
`default_nettype wire

/* File: verification/ref_path_model.sv */
`timescale 1ns/1ps
`default_nettype none
// reference source upstream and force consumer downstream of the block
module ref_path_model (
	input wire logic clk, // 125 MHz
	input wire logic reset, // sync, active high
	input wire logic fire, // launch one sample
	input wire logic signed [15:0] frc, // force to send
	input wire logic signed [15:0] spd, // speed to send
	input wire logic signed [15:0] acc, // accel to send
	input wire logic signed [15:0] err, // error to send
	input wire logic pos_mode, // position control to send
	output logic sample_valid, // sample strobe to block
	output logic signed [15:0] force_ref, // to block
	output logic signed [15:0] speed_ref, // to block
	output logic signed [15:0] accel_ref, // to block
	output logic signed [15:0] pos_err, // to block
	output logic position_mode, // to block
	input wire logic out_valid, // from block
	input wire logic signed [15:0] force_filt, // from block
	output logic signed [15:0] last_force, // last force taken
	output logic [15:0] n_out // samples taken
);
	// refs launched together with the strobe, so they stand with it
	always_ff @(posedge clk) begin
		if (reset) begin
			sample_valid <= 1'b0;
			force_ref <= 16'sh0000;
			speed_ref <= 16'sh0000;
			accel_ref <= 16'sh0000;
			pos_err <= 16'sh0000;
			position_mode <= 1'b0;
			last_force <= 16'sh0000;
			n_out <= 16'h0000;
		end else begin
			sample_valid <= fire;
			force_ref <= frc;
			speed_ref <= spd;
			accel_ref <= acc;
			pos_err <= err;
			position_mode <= pos_mode;
			if (out_valid) begin
				last_force <= force_filt;
				n_out <= n_out + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] address = 5'h00;
	logic read = 1'b0, write = 1'b0, fire = 1'b0, pos_mode = 1'b0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h00000000, readdata, rd;
	logic waitrequest, sample_valid, position_mode, p_control, out_valid;
	logic signed [15:0] force_ref, speed_ref, accel_ref, pos_err;
	logic signed [15:0] force_filt, pos_integral, last_force;
	logic signed [15:0] frc = 16'sh0000, spd = 16'sh0000;
	logic signed [15:0] acc = 16'sh0000, err = 16'sh0000;
	logic [15:0] n_out, n0;
	int n_errors = 0, n_checks = 0;
	logic [15:0] rst_exp [18] = '{16'h0000, 16'h00C8, 16'h0000, 16'h0000,
		16'h0000, 16'h0064, 16'h1388, 16'h0032, 16'h0000, 16'h1388,
		16'h0046, 16'h0000, 16'h1388, 16'h0046, 16'h0000, 16'h0000,
		16'h0028, 16'h0000};
	logic [15:0] thr [4] = '{16'h00C8, 16'h0064, 16'h0064, 16'h0064};
	logic [15:0] en [3] = '{16'h0001, 16'h0100, 16'h0010};
	logic [15:0] st [3] = '{16'h0008, 16'h0010, 16'h0000};

	always #4 clk = ~clk;

	pi_mode_switch_force_filter uut (.clk, .reset, .address, .read, .write,
		.byteenable, .writedata, .readdata, .waitrequest, .sample_valid,
		.force_ref, .speed_ref, .accel_ref, .pos_err, .position_mode,
		.p_control, .force_filt, .pos_integral, .out_valid);
	ref_path_model partner (.clk, .reset, .fire, .frc, .spd, .acc, .err,
		.pos_mode, .sample_valid, .force_ref, .speed_ref, .accel_ref,
		.pos_err, .position_mode, .out_valid, .force_filt, .last_force,
		.n_out);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [3:0] be, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		byteenable <= be;
		writedata <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			chk("bus answer", 32'h1, 32'h0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		bus(1'b1, a, 4'h3, d);
	endtask

	task automatic rdchk(input string nm, input logic [4:0] a,
		input logic [15:0] e);
		bus(1'b0, a, 4'h3, 16'h0000);
		chk(nm, {16'h0000, e}, rd);
	endtask

	// one sample on the selected quantity, others zero
	task automatic drive(input int c, input logic [15:0] v, input logic pm);
		@(posedge clk);
		frc <= (c == 0) ? v : 16'h0000;
		spd <= (c == 1) ? v : 16'h0000;
		acc <= (c == 2) ? v : 16'h0000;
		err <= (c == 3) ? v : 16'h0000;
		pos_mode <= pm;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 18; i++)
			rdchk("reset value", 5'(i), rst_exp[i]);
		rdchk("unmapped read", 5'h1F, 16'h0000);
		wreg(5'h1F, 16'hFFFF);
		rdchk("unmapped after write", 5'h1F, 16'h0000);
		wreg(5'h02, 16'h1234);
		bus(1'b1, 5'h02, 4'h1, 16'hABCD);
		rdchk("low lane write", 5'h02, 16'h12CD);
		wreg(5'h10, 16'h0019);
		rdchk("speed gain", 5'h10, 16'h0019);
		$display("test registers done");
		for (int c = 0; c < 4; c++) begin
			wreg(5'h00, 16'(c));
			wreg(5'(c + 1), thr[c]);
			drive(c, thr[c], 1'b1);
			chk("p at threshold", 32'h0, {31'h0, p_control});
			drive(c, thr[c] + 16'h0001, 1'b1);
			chk("p above", 32'h1, {31'h0, p_control});
			drive(c, 16'h0000 - thr[c] - 16'h0001, 1'b1);
			chk("p negative", 32'h1, {31'h0, p_control});
			drive(c, 16'h0000, 1'b1);
			chk("p back to pi", 32'h0, {31'h0, p_control});
		end
		drive(3, 16'h7000, 1'b0);
		chk("p error outside position", 32'h0, {31'h0, p_control});
		wreg(5'h00, 16'h0004);
		drive(0, 16'h7530, 1'b1);
		chk("p unused", 32'h0, {31'h0, p_control});
		wreg(5'h00, 16'h0009);
		drive(0, 16'h7530, 1'b1);
		chk("p unused code", 32'h0, {31'h0, p_control});
		wreg(5'h00, 16'h0010);
		drive(0, 16'h00C9, 1'b1);
		chk("p low digit", 32'h1, {31'h0, p_control});
		$display("test mode switch done");
		wreg(5'h05, 16'h0000);
		n0 = n_out;
		drive(0, 16'h04D2, 1'b0);
		chk("bypass output", 32'h04D2, {16'h0000, last_force});
		chk("one out per sample", {16'h0000, n0 + 16'h1}, {16'h0000, n_out});
		// 0.9 ms lag stays under the stability bound of the 25 Hz gain
		wreg(5'h05, 16'h005A);
		drive(0, 16'h0000, 1'b0);
		chk("lag step", 32'h1, {31'h0, last_force > 0 && last_force < 1234});
		$display("test filter done");
		// notches stay at 5000 Hz, far above the loop, never moved in motion
		for (int i = 0; i < 3; i++) begin
			wreg(5'h08, en[i]);
			rdchk("notch status", 5'h11, st[i]);
		end
		wreg(5'h06, 16'h03E8);
		rdchk("second stage on", 5'h11, 16'h0004);
		wreg(5'h06, 16'h1388);
		wreg(5'h11, 16'hFFFF);
		rdchk("status read only", 5'h11, 16'h0000);
		$display("test status done");
		wreg(5'h0F, 16'h000A);
		rdchk("integral on", 5'h11, 16'h0002);
		drive(3, 16'h03E8, 1'b1);
		drive(3, 16'h03E8, 1'b1);
		chk("integral grows", 32'h1, {31'h0, pos_integral > 0});
		wreg(5'h0F, 16'h0000);
		drive(3, 16'h03E8, 1'b1);
		chk("integral off", 32'h0, {16'h0000, pos_integral});
		$display("test integral done");
		print_verdict();
	end
endmodule
`default_nettype wire
